// ==== core/tcm_pkg.sv ====
// Purpose: shared constants and state types of the connection control block
// Assumes: 100 MHz clk, one clk period equals half a serial clock period
// Notes: byte addresses on the register bus are 12-bit word aligned offsets
package tcm_pkg;

  // sizes of the switch
  localparam int NSTREAM = 16;           // input and output streams
  localparam int CM_AW = 11;             // stream(4) + channel(7)
  localparam int CM_WORDS = 2048;        // connection words held
  localparam int WORD_W = 16;            // connection word width
  localparam int REC_W = 26;             // steering record width
  localparam int FIFO_D = 16;            // steering fifo depth

  // connection word field positions
  localparam int B_LOOP = 15;            // per channel loopback
  localparam int B_CONST = 14;           // constant throughput delay
  localparam int B_MSG = 13;             // message select
  localparam int B_CST = 12;             // control serial bit
  localparam int B_OE = 11;              // output driver enable
  localparam int B_SRC_HI = 10;          // source stream field msb
  localparam int B_SRC_LO = 7;           // source stream field lsb
  localparam int B_CH_HI = 6;            // source channel field msb

  // register byte offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_MEAS = 12'h008;
  localparam logic [11:0] A_CM_ADDR = 12'h00C;
  localparam logic [11:0] A_CM_DATA = 12'h010;
  localparam logic [11:0] A_OFS_BASE = 12'h040; // 16 words to 0x07C

  // register field positions
  localparam int ST_OVR_BIT = 8;         // status overrun, write 1 clears
  localparam int ST_RUN_BIT = 7;         // status frame running

  // data rate encodings
  localparam logic [1:0] RATE_2M = 2'h0; // 32 channels
  localparam logic [1:0] RATE_4M = 2'h1; // 64 channels
  localparam logic [1:0] RATE_8M = 2'h2; // 128 channels

  // reset values
  localparam logic [3:0] OFS_RST = 4'h0;
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic GCI_RST = 1'b0;

  // half period counting
  localparam logic [3:0] HP_MAX = 4'h9;  // 4.5 periods in half periods
  localparam logic [3:0] HP_SAT = 4'hF;  // counter ceiling
  localparam logic [3:0] SLOT_LAST = 4'hF; // one cycle per stream

  // whole state of the top block
  typedef struct packed {
    logic gci;                     // gci bus sense of latch edge
    logic [1:0] rate;              // data rate select
    logic [15:0][3:0] ofs;         // {whole[2:0], half} per stream
    logic [3:0] msel;              // stream under measurement
    logic [3:0] mval;              // {integer flag, period count}
    logic mdone;                   // measurement captured
    logic marm;                    // measurement armed
    logic [10:0] cm_addr;          // connection word pointer
    logic [2:0] fp_s;              // frame pulse synchroniser
    logic fp_lvl;                  // filtered frame pulse
    logic [2:0] fe_s;              // frame eval synchroniser
    logic fe_lvl;                  // filtered frame eval
    logic [3:0] hp;                // half periods since frame pulse
    logic run;                     // a frame pulse has been seen
    logic [3:0] scyc;              // stream scanned in this slot
    logic [6:0] ch;                // current channel
    logic cst;                     // control serial out bit
    logic [15:0] fstart;           // per stream bit 0 strobe
    logic [15:0] fall;             // per stream sample on falling edge
    logic ovr;                     // steering fifo stalled the scan
    logic wp;                      // write data phase pending
    logic [11:0] wa;               // write address
    logic rdp;                     // read wait cycle pending
    logic [11:0] ra;               // read address
    logic rdy;                     // hreadyout
    logic [31:0] rdata;            // hrdata
  } tcm_state_t;

endpackage

// ==== core/tcm_fifo.sv ====
// Purpose: small flip-flop fifo with valid and ready on both sides
// Assumes: one clock, push and pop may happen in the same cycle
// Notes: in_ready is low while full, out_valid low while empty
module tcm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;  // storage
    logic [PW-1:0] wp;         // write index
    logic [PW-1:0] rp;         // read index
    logic [PW:0] cnt;          // words held
  } tcm_fifo_st_t;

  tcm_fifo_st_t st_reg, st_next;
  logic push, pop;

  // honest flags straight from the count
  assign in_ready = (st_reg.cnt != (PW+1)'(D));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == PW'(D-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == PW'(D-1)) ? '0 : st_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: st_next.cnt = st_reg.cnt + 1'b1;
      2'b01: st_next.cnt = st_reg.cnt - 1'b1;
      default: st_next.cnt = st_reg.cnt;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== core/tcm_conn_mem.sv ====
// Purpose: connection word storage, one word per output stream and channel
// Assumes: index is {stream[3:0], channel[6:0]}
// Notes: two combinational read ports, one write port; reset clears all
module tcm_conn_mem (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write port
  input wire logic wr_en,
  input wire logic [10:0] wr_addr,
  input wire logic [15:0] wr_data,
  // scan read port
  input wire logic [10:0] a_addr,
  output logic [15:0] a_data,
  // bus read port
  input wire logic [10:0] b_addr,
  output logic [15:0] b_data
);
  typedef struct packed {
    logic [tcm_pkg::CM_WORDS-1:0][tcm_pkg::WORD_W-1:0] mem;
  } tcm_mem_st_t;

  tcm_mem_st_t st_reg, st_next;

  // reads see the stored word, a write lands at the next edge
  assign a_data = st_reg.mem[a_addr];
  assign b_data = st_reg.mem[b_addr];

  // write path
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.mem[wr_addr] = wr_data;
    end
  end

  // cleared words keep drivers off and message mode off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== core/tcm_ctrl.sv ====
// Purpose: per channel connection control of a time slot switch
// Assumes: clk period is half a serial clock period; AHB-Lite sole slave
// Notes: data memory and serial shifters sit outside and use the strobes
//
// Overview of operation
// - offset is whole periods plus half period
// - reset leaves every stream offset at zero
// - measured delay: integer flag and period count
// - bit 15 loops output channel into input
// - bit 14 picks constant or variable delay
// - bit 13 set sends low byte as message
// - bit 13 clear means source stream and channel
// - bit 12 goes out early, stream 0 first
// - bit 11 enables output driver per channel
// - bits 10 to 7 give source stream
// - bits 6 to 0 give source channel
// - channel field width follows data rate
// - receiver waits offset after frame pulse
// - latch edge bit picks sampling edge, gci reversed
// - sixteen independent stream offset fields
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
module tcm_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // frame pins
  input wire logic frame_pulse_input,
  input wire logic frame_eval_input,
  // receiver timing
  output logic [15:0] frame_start_stream,
  output logic [15:0] sample_on_falling,
  output logic control_serial_out,
  // steering records to the data path
  output logic steer_valid,
  input wire logic steer_ready,
  output logic [3:0] steer_stream,
  output logic [6:0] steer_channel,
  output logic steer_loopback,
  output logic steer_const_delay,
  output logic steer_message,
  output logic steer_oe,
  output logic [10:0] steer_payload
);

  tcm_pkg::tcm_state_t st_reg, st_next;

  // decoding shared by the read and write paths
  function automatic logic is_ofs(input logic [11:0] a);
    is_ofs = (a[11:6] == tcm_pkg::A_OFS_BASE[11:6]) && (a[1:0] == 2'h0);
  endfunction

  // last channel of a frame for a rate
  function automatic logic [6:0] last_ch(input logic [1:0] r);
    case (r)
      tcm_pkg::RATE_2M: last_ch = 7'h1F;
      tcm_pkg::RATE_4M: last_ch = 7'h3F;
      default: last_ch = 7'h7F;
    endcase
  endfunction

  // bus, scan and frame timing wires
  logic addr_ok;          // a transfer is taken this edge
  logic cm_we;            // connection word write
  logic [15:0] cm_a_data; // word under scan
  logic [15:0] cm_b_data; // word for the bus
  logic [10:0] scan_addr; // {stream, next channel}
  logic [6:0] next_ch;    // channel one slot ahead
  localparam int REC_W_L = tcm_pkg::REC_W;
  logic [REC_W_L-1:0] rec;
  logic rec_ready;        // fifo can take a record
  logic scan_go;          // record accepted this cycle
  logic fp_rise;          // filtered frame pulse rising
  logic fe_rise;          // filtered frame eval rising
  logic [3:0] hp_nx;      // half period count next cycle
  logic run_nx;           // frame running next cycle
  logic [15:0] hit;       // per stream offset reached
  logic [6:0] src_ch;     // channel field masked by rate
  logic [10:0] payload;   // source address or message byte
  logic [REC_W_L-1:0] fifo_out;

  // only a nonseq or seq transfer with hready is taken
  assign addr_ok = hsel && htrans[1] && hready;

  // write to the data register lands in the data phase
  assign cm_we = st_reg.wp && (st_reg.wa == tcm_pkg::A_CM_DATA);

  // filtered edges; the first synchroniser stage is not read here
  assign fp_rise = (st_reg.fp_s[1] == st_reg.fp_s[2]) && st_reg.fp_s[2]
                   && !st_reg.fp_lvl;
  assign fe_rise = (st_reg.fe_s[1] == st_reg.fe_s[2]) && st_reg.fe_s[2]
                   && !st_reg.fe_lvl;

  // half periods counted from the frame pulse, saturating
  always_comb begin
    hp_nx = st_reg.hp;
    run_nx = st_reg.run;
    if (fp_rise) begin
      hp_nx = 4'h0;
      run_nx = 1'b1;
    end else if (st_reg.run && st_reg.hp != tcm_pkg::HP_SAT) begin
      hp_nx = st_reg.hp + 4'h1;
    end
  end

  // per stream compare of the count with {whole, half}
  genvar gi;
  generate
    for (gi = 0; gi < tcm_pkg::NSTREAM; gi++) begin : g_ofs
      // bit 0 of a frame is taken once the offset has elapsed
      assign hit[gi] = run_nx && (hp_nx == st_reg.ofs[gi]);
    end
  endgenerate

  // scan looks one channel ahead of the current slot
  assign next_ch = (st_reg.ch >= last_ch(st_reg.rate)) ? 7'h00
                   : st_reg.ch + 7'h01;
  assign scan_addr = {st_reg.scyc, next_ch};

  // channel field narrows with the data rate
  always_comb begin
    case (st_reg.rate)
      tcm_pkg::RATE_2M: src_ch = {2'h0, cm_a_data[4:0]};
      tcm_pkg::RATE_4M: src_ch = {1'h0, cm_a_data[5:0]};
      default: src_ch = cm_a_data[tcm_pkg::B_CH_HI:0];
    endcase
  end

  // message byte or source address
  always_comb begin
    if (cm_a_data[tcm_pkg::B_MSG]) begin
      payload = {3'h0, cm_a_data[7:0]};
    end else begin
      // source stream above source channel
      payload = {cm_a_data[tcm_pkg::B_SRC_HI:tcm_pkg::B_SRC_LO],
                 src_ch};
    end
  end

  // record: flags, output position, payload
  assign rec = {cm_a_data[tcm_pkg::B_LOOP],
                cm_a_data[tcm_pkg::B_CONST],
                cm_a_data[tcm_pkg::B_MSG],
                cm_a_data[tcm_pkg::B_OE],
                st_reg.scyc, next_ch, payload};

  // the scan stalls while the fifo is full, so no record is lost
  assign scan_go = st_reg.run && rec_ready;

  // next state
  always_comb begin
    st_next = st_reg;

    // three stage synchronisers with agreement filter
    st_next.fp_s = {st_reg.fp_s[1:0], frame_pulse_input};
    st_next.fe_s = {st_reg.fe_s[1:0], frame_eval_input};
    if (st_reg.fp_s[1] == st_reg.fp_s[2]) begin
      st_next.fp_lvl = st_reg.fp_s[2];
    end
    if (st_reg.fe_s[1] == st_reg.fe_s[2]) begin
      st_next.fe_lvl = st_reg.fe_s[2];
    end

    // frame timing
    st_next.hp = hp_nx;
    st_next.run = run_nx;
    st_next.fstart = hit;

    // sampling edge sense flips in gci mode
    for (int i = 0; i < tcm_pkg::NSTREAM; i++) begin
      st_next.fall[i] = st_reg.ofs[i][0] ^ st_reg.gci;
    end

    // channel scan, one stream per cycle, stream 0 first
    if (fp_rise) begin
      st_next.scyc = 4'h0;
      st_next.ch = 7'h00;
    end else if (scan_go) begin
      // control bit leaves one channel ahead of its slot
      st_next.cst = cm_a_data[tcm_pkg::B_CST];
      st_next.scyc = st_reg.scyc + 4'h1;
      if (st_reg.scyc == tcm_pkg::SLOT_LAST) begin
        st_next.ch = next_ch;
      end
    end

    // measurement: half periods from frame pulse to eval edge
    // count as of this edge, so eval together with the pulse reads zero
    if (st_reg.marm && run_nx && fe_rise) begin
      if (hp_nx > tcm_pkg::HP_MAX) begin
        // beyond 4.5 periods the reading is clamped
        st_next.mval = {~tcm_pkg::HP_MAX[0], tcm_pkg::HP_MAX[3:1]};
      end else begin
        // even count is a whole number of periods
        st_next.mval = {~hp_nx[0], hp_nx[3:1]};
      end
      st_next.mdone = 1'b1;
      st_next.marm = 1'b0;
    end

    // bus address phase
    st_next.wp = 1'b0;
    if (st_reg.rdp) begin
      // wait cycle over; read data is final
      st_next.rdp = 1'b0;
      st_next.rdy = 1'b1;
      st_next.rdata = 32'h0000_0000;
      if (is_ofs(st_reg.ra)) begin
        st_next.rdata[3:0] = st_reg.ofs[st_reg.ra[5:2]];
      end else begin
        case (st_reg.ra)
          tcm_pkg::A_CTRL: begin
            st_next.rdata[2:0] = {st_reg.rate, st_reg.gci};
          end
          tcm_pkg::A_STATUS: begin
            st_next.rdata[6:0] = st_reg.ch;
            st_next.rdata[tcm_pkg::ST_RUN_BIT] = st_reg.run;
            st_next.rdata[tcm_pkg::ST_OVR_BIT] = st_reg.ovr;
          end
          tcm_pkg::A_MEAS: begin
            st_next.rdata[9:0] = {st_reg.marm, st_reg.mdone,
                                  st_reg.mval, st_reg.msel};
          end
          tcm_pkg::A_CM_ADDR: begin
            st_next.rdata[10:0] = st_reg.cm_addr;
          end
          tcm_pkg::A_CM_DATA: begin
            st_next.rdata[15:0] = cm_b_data;
          end
          default: begin
            // unmapped reads return zero
            st_next.rdata = 32'h0000_0000;
          end
        endcase
      end
    end else if (addr_ok) begin
      if (hwrite) begin
        st_next.wp = 1'b1;
        st_next.wa = haddr[11:0];
      end else begin
        // one wait cycle lets a just written word be read back
        st_next.rdp = 1'b1;
        st_next.rdy = 1'b0;
        st_next.ra = haddr[11:0];
      end
    end

    // bus write data phase
    if (st_reg.wp) begin
      if (is_ofs(st_reg.wa)) begin
        st_next.ofs[st_reg.wa[5:2]] = hwdata[3:0];
      end else begin
        case (st_reg.wa)
          tcm_pkg::A_CTRL: begin
            st_next.gci = hwdata[0];
            st_next.rate = hwdata[2:1];
          end
          tcm_pkg::A_MEAS: begin
            st_next.msel = hwdata[3:0];
            st_next.marm = 1'b1;
            st_next.mdone = 1'b0;
          end
          tcm_pkg::A_CM_ADDR: begin
            st_next.cm_addr = hwdata[10:0];
          end
          default: begin
            // status clear is handled below, data word write by cm_we; others ignored
          end
        endcase
      end
    end

    // overrun is sticky; a new stall beats a clear
    st_next.ovr = (st_reg.ovr && !(st_reg.wp
                  && st_reg.wa == tcm_pkg::A_STATUS
                  && hwdata[tcm_pkg::ST_OVR_BIT]))
                  || (st_reg.run && !rec_ready);
  end

  // state register with constant reset values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.rate <= tcm_pkg::RATE_RST;
      st_reg.gci <= tcm_pkg::GCI_RST;
      st_reg.ofs <= {tcm_pkg::NSTREAM{tcm_pkg::OFS_RST}};
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // connection words
  tcm_conn_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .wr_en(cm_we),
    .wr_addr(st_reg.cm_addr),
    .wr_data(hwdata[15:0]),
    .a_addr(scan_addr),
    .a_data(cm_a_data),
    .b_addr(st_reg.cm_addr),
    .b_data(cm_b_data)
  );

  // steering records wait here for the data path
  tcm_fifo #(
    .W(tcm_pkg::REC_W),
    .D(tcm_pkg::FIFO_D)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(st_reg.run),
    .in_ready(rec_ready),
    .in_data(rec),
    .out_valid(steer_valid),
    .out_ready(steer_ready),
    .out_data(fifo_out)
  );

  // record fields out as separate ports
  assign steer_loopback = fifo_out[25];
  assign steer_const_delay = fifo_out[24];
  assign steer_message = fifo_out[23];
  assign steer_oe = fifo_out[22];
  assign steer_stream = fifo_out[21:18];
  assign steer_channel = fifo_out[17:11];
  assign steer_payload = fifo_out[10:0];

  // pin and bus outputs from the state register, hresp tied to okay
  assign frame_start_stream = st_reg.fstart;
  assign sample_on_falling = st_reg.fall;
  assign control_serial_out = st_reg.cst;
  assign hreadyout = st_reg.rdy;
  assign hrdata = st_reg.rdata;
  assign hresp = 1'b0;
endmodule

// ==== tb/tcm_ctrl_asserts.sv ====
// Purpose: port level checks of the connection control block
// Assumes: one clk domain, nrst asynchronous and active low
// Notes: bound into every tcm_ctrl instance at the foot of this file
module tcm_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // frame timing
  input wire logic frame_pulse_input,
  input wire logic [15:0] frame_start_stream,
  input wire logic [15:0] sample_on_falling,
  // steering records
  input wire logic steer_valid,
  input wire logic steer_ready,
  input wire logic [3:0] steer_stream,
  input wire logic steer_message,
  input wire logic [10:0] steer_payload
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // request accepted at this edge
  wire take = hsel & htrans[1] & hready;
  // write data phase marker, offsets may change only after it
  logic wr_dp;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) wr_dp <= 1'b0;
    else wr_dp <= take & hwrite;
  end
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  steer_hold_a: assert property (steer_valid && !steer_ready |=>
    steer_valid && $stable(steer_stream) && $stable(steer_payload))
    else $error("record dropped while stalled");
  msg_pad_a: assert property (
    steer_valid && steer_message |-> steer_payload[10:8] == 3'h0)
    else $error("message payload not a byte");
  start_once_a: assert property (
    frame_start_stream[0] |=> !frame_start_stream[0])
    else $error("frame start longer than a cycle");
  start_bound_a: assert property (
    $rose(frame_pulse_input) |-> ##[3:16] frame_start_stream[0])
    else $error("stream 0 frame start missing");
  edge_stable_a: assert property (
    $changed(sample_on_falling) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("latch edge changed without write");
  // main scenarios
  rd_c: cover property (take && !hwrite);
  stall_c: cover property (steer_valid && !steer_ready);
  msg_c: cover property (steer_valid && steer_message);
endmodule
bind tcm_ctrl tcm_ctrl_chk u_chk (.clk(clk), .nrst(nrst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .frame_pulse_input(frame_pulse_input),
  .frame_start_stream(frame_start_stream),
  .sample_on_falling(sample_on_falling), .steer_valid(steer_valid),
  .steer_ready(steer_ready), .steer_stream(steer_stream),
  .steer_message(steer_message), .steer_payload(steer_payload));

// ==== tb/tcm_far.sv ====
// Purpose: far side model: frame pins and the data path draining records
// Assumes: record is {stream, channel, loop, const, msg, oe, payload}
// Notes: keeps the last record seen for stream 0 and 1, channel 1
module tcm_far (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench controls
  input wire logic go,
  input wire logic [3:0] lag,
  input wire logic stall,
  // frame pins
  output logic fp,
  output logic fe,
  // record drain
  input wire logic steer_valid,
  output logic steer_ready,
  input wire logic [25:0] rec,
  output logic [25:0] got0,
  output logic [25:0] got1
);
  // cycles since go; pins idle low between frames
  logic [4:0] t;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) t <= 5'h00;
    else if (go) t <= 5'h01;
    else if (t != 5'h00 && t < 5'h14) t <= t + 5'h01;
    else t <= 5'h00;
  end
  // held six cycles so the input filter accepts it
  assign fp = t >= 5'h01 && t <= 5'h06;
  assign fe = lag != 4'h0 && t > {1'b0, lag} && t <= {1'b0, lag} + 5'h06;
  // a slow data path refuses records while stalled
  assign steer_ready = !stall;
  // capture of the watched records
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      got0 <= 26'h0;
      got1 <= 26'h0;
    end else if (steer_valid && steer_ready && rec[21:15] == 7'h01) begin
      if (rec[25:22] == 4'h0) got0 <= rec;
      if (rec[25:22] == 4'h1) got1 <= rec;
    end
  end
endmodule

// ==== tb/test_tdm_connection_memory_control.sv ====
// Purpose: self checking bench of the connection control block
// Assumes: sole bus slave, hready tied to hreadyout
// Notes: scenarios run in order; scan keeps running after first frame
module test_tdm_connection_memory_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hready, hresp, fp, fe, cso, sv, sr, go = 1'b0, stall = 1'b0;
  logic [3:0] lag = 4'h0, s_st;
  logic [6:0] s_ch;
  logic [3:0] s_b;
  logic [10:0] s_pl;
  logic [15:0] fss, sof;
  logic [25:0] got0, got1;
  int bad_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] r;
  always #5 clk = ~clk;
  tcm_ctrl dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .frame_pulse_input(fp), .frame_eval_input(fe),
    .frame_start_stream(fss), .sample_on_falling(sof),
    .control_serial_out(cso), .steer_valid(sv), .steer_ready(sr),
    .steer_stream(s_st), .steer_channel(s_ch), .steer_loopback(s_b[3]),
    .steer_const_delay(s_b[2]), .steer_message(s_b[1]),
    .steer_oe(s_b[0]), .steer_payload(s_pl));
  tcm_far far (.clk(clk), .nrst(nrst), .go(go), .lag(lag), .stall(stall),
    .fp(fp), .fe(fe), .steer_valid(sv), .steer_ready(sr),
    .rec({s_st, s_ch, s_b, s_pl}), .got0(got0), .got1(got1));
  // verdict and end of run
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single AHB-Lite transfer, waits for hready at each phase
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic pulse(input int n);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // defaults after reset and an unmapped place
  task automatic t_reset();
    for (int n = 0; n < 16; n++) begin
      rd(tcm_pkg::A_OFS_BASE + 12'(4 * n));
      chk("ofs_rst", 32'h0, r);
    end
    rd(tcm_pkg::A_CTRL);
    chk("ctrl_rst", 32'h4, r);
    rd(12'h800);
    chk("unmapped", 32'h0, r);
  endtask
  // message and switched words reach the data path in scan order
  task automatic t_steer();
    wr(tcm_pkg::A_OFS_BASE, 32'h0);
    wr(tcm_pkg::A_CM_ADDR, 32'h001);
    wr(tcm_pkg::A_CM_DATA, 32'hF8A5);
    rd(tcm_pkg::A_CM_DATA);
    chk("cm_rd", 32'hF8A5, r);
    wr(tcm_pkg::A_CM_ADDR, 32'h081);
    wr(tcm_pkg::A_CM_DATA, 32'h4AC5);
    pulse(0);
    for (int i = 0; i < 40 && sv !== 1'b1; i++) @(posedge clk) #1;
    chk("cst_first", 32'h1, {31'h0, cso});
    chk("first_stream", 32'h0, {28'h0, s_st});
    repeat (100) @(posedge clk);
    chk("msg_rec", {6'h0, 4'h0, 7'h01, 4'hF, 11'h0A5},
      {6'h0, got0});
    chk("sw_rec", {6'h0, 4'h1, 7'h01, 4'h5, 4'h5, 7'h45},
      {6'h0, got1});
    wr(tcm_pkg::A_CTRL, 32'h0);
    repeat (600) @(posedge clk);
    chk("sw_rec_32", {6'h0, 4'h1, 7'h01, 4'h5, 4'h5, 7'h05},
      {6'h0, got1});
    wr(tcm_pkg::A_CTRL, 32'h4);
  endtask
  // stream n below 10 delayed by n half periods, ten encodings
  task automatic t_frame();
    logic [7:0] t [16];
    logic [3:0] v;
    for (int n = 0; n < 16; n++) begin
      v = n < 10 ? 4'(n) : 4'h0;
      wr(tcm_pkg::A_OFS_BASE + 12'(4 * n), {28'h0, v});
      rd(tcm_pkg::A_OFS_BASE + 12'(4 * n));
      chk("ofs_rw", {28'h0, v}, r);
      t[n] = 8'hFF;
    end
    chk("edge_st", 32'h02AA, {16'h0, sof});
    wr(tcm_pkg::A_CTRL, 32'h5);
    rd(tcm_pkg::A_CTRL);
    chk("edge_gci", 32'hFD55, {16'h0, sof});
    wr(tcm_pkg::A_CTRL, 32'h4);
    pulse(0);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk) #1;
      for (int n = 0; n < 16; n++)
        if (fss[n] === 1'b1 && t[n] == 8'hFF) t[n] = 8'(i);
    end
    for (int n = 0; n < 16; n++)
      chk("ofs_delay", n < 10 ? n : 0, {24'h0, t[n] - t[0]});
  endtask
  // eval pin three half periods after the frame pulse
  task automatic t_meas();
    wr(tcm_pkg::A_MEAS, 32'h0);
    lag <= 4'h3;
    pulse(30);
    rd(tcm_pkg::A_MEAS);
    chk("meas", 32'h11, {27'h0, r[8:4]});
    lag <= 4'h0;
  endtask
  // data path stalls, fifo fills, overrun sticks until cleared
  task automatic t_stall();
    stall <= 1'b1;
    repeat (60) @(posedge clk);
    rd(tcm_pkg::A_STATUS);
    chk("ovr_set", 32'h1, {31'h0, r[tcm_pkg::ST_OVR_BIT]});
    chk("held", 32'h1, {31'h0, sv});
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    wr(tcm_pkg::A_STATUS, 32'h100);
    rd(tcm_pkg::A_STATUS);
    chk("ovr_clr", 32'h0, {31'h0, r[tcm_pkg::ST_OVR_BIT]});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_steer();
    t_frame();
    t_meas();
    t_stall();
    finish_test();
  end
endmodule
